// [bench/dmxaa_far_model.sv]
`timescale 1ns/100ps

// ----------
// far side: upstream chain chip and retained storage
// ----------
module dmxaa_far_model (
    // clock and reset
    input  wire logic                     mclk,
    input  wire logic                     resetn,
    // frame timing and the frame at which upstream takes its turn
    input  wire logic                     frame_start,
    input  wire logic [3:0]               up_turn,
    // storage port of the block
    input  wire logic                     nvm_wr,
    input  wire dmxaa_pkg::dmxaa_cfg_type nvm_data,
    // toward the block
    output logic                          chain_addr_in,
    output dmxaa_pkg::dmxaa_cfg_type      nvm_rd
);
    int frames;

    // storage is not cleared by reset, as a power cycle keeps it
    initial begin
        nvm_rd = '0;
        nvm_rd.addr = dmxaa_pkg::FIRST_ADDR;
        nvm_rd.step = dmxaa_pkg::STEP_RST;
    end

    always @(posedge mclk) begin
        if (nvm_wr) begin
            nvm_rd <= nvm_data;
        end
    end

    // upstream raises its output at frame up_turn, zero means never
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            frames <= 0;
            chain_addr_in <= 1'b0;
        end else if (frame_start) begin
            frames <= frames + 1;
            if (frames + 1 == int'(up_turn)) begin
                chain_addr_in <= 1'b1;
            end
        end
    end
endmodule : dmxaa_far_model

// [bench/tb.sv]
`timescale 1ns/100ps

`define CHK(nm, ex, gt) begin \
    n_compared++; \
    if ((gt) !== (ex)) begin \
        err_count++; \
        $display("wrong value %s expected %0h seen %0h", nm, ex, gt); \
    end \
end

module tb;
    // ----------
    // signals and model state
    // ----------
    localparam int IND   = 20;
    localparam int LIMIT = 5000;
    logic                       mclk;
    logic                       resetn;
    logic                       frame_start;
    logic                       chain_addr_in;
    logic                       chain_in_float;
    logic                       chain_addr_out;
    logic                       nvm_wr;
    logic [3:0]                 pwm_raw;
    logic [3:0]                 led;
    logic [3:0]                 up_turn;
    logic [3:0]                 col;
    logic [19:0]                got_cfg;
    dmxaa_pkg::dmxaa_cmd_type   cmd;
    dmxaa_pkg::dmxaa_learn_type learn;
    dmxaa_pkg::dmxaa_cfg_type   nvm_rd;
    dmxaa_pkg::dmxaa_cfg_type   nvm_data;
    int err_count, n_compared, m_addr, m_step, m_mode;
    int k, j, s, t, w, nfr;
    int cycles = 0;

    assign got_cfg = {nvm_data.addr, nvm_data.step, nvm_data.mode};

    dmxaa_ctrl #(.IND_CYCLES(IND)) uut (
        .mclk               (mclk),
        .resetn             (resetn),
        .cmd                (cmd),
        .frame_start        (frame_start),
        .learn              (learn),
        .chain_addr_in      (chain_addr_in),
        .chain_in_float     (chain_in_float),
        .chain_addr_out     (chain_addr_out),
        .nvm_rd             (nvm_rd),
        .nvm_wr             (nvm_wr),
        .nvm_data           (nvm_data),
        .pwm_raw            (pwm_raw),
        .led_channel_outputs(led)
    );

    dmxaa_far_model far (
        .mclk         (mclk),
        .resetn       (resetn),
        .frame_start  (frame_start),
        .up_turn      (up_turn),
        .nvm_wr       (nvm_wr),
        .nvm_data     (nvm_data),
        .chain_addr_in(chain_addr_in),
        .nvm_rd       (nvm_rd)
    );

    always begin
        #25 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            wrap_up();
        end
    end

    // ----------
    // model and stimulus tasks
    // ----------
    function automatic logic [19:0] want();
        return {9'(m_addr), 9'(m_step), 2'(m_mode)};
    endfunction : want

    task automatic wrap_up();
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic send(input dmxaa_pkg::dmxaa_op_type op, input int d);
        @(posedge mclk);
        cmd <= '{valid: 1'b1, op: op, data: 16'(d)};
        @(posedge mclk);
        cmd.valid <= 1'b0;
    endtask : send

    // returns with the store pulse high, one rising edge before the stored copy takes the new settings
    task automatic issue(input dmxaa_pkg::dmxaa_op_type op, input int d);
        send(op, d);
        @(negedge mclk);
    endtask : issue

    task automatic count_col(input logic [3:0] c, input int n);
        w = 0;
        repeat (n) begin
            @(negedge mclk);
            if (led === c) w++;
        end
    endtask : count_col

    task automatic power_up(input logic flt);
        @(posedge mclk);
        resetn <= 1'b0;
        chain_in_float <= flt;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask : power_up

    task automatic frame();
        @(posedge mclk);
        frame_start <= 1'b1;
        @(posedge mclk);
        frame_start <= 1'b0;
        @(negedge mclk);
    endtask : frame

    // ----------
    // sequence
    // ----------
    initial begin
        mclk = 1'b0;
        resetn = 1'b0;
        frame_start = 1'b0;
        chain_in_float = 1'b1;
        pwm_raw = 4'h0;
        up_turn = 4'h0;
        cmd = '0;
        learn = '0;
        err_count = 0;
        n_compared = 0;
        void'($urandom(32'hD2EE4958));
        m_addr = 1;
        m_step = 1;
        m_mode = 0;
        repeat (7) @(negedge mclk);
        `CHK("config in reset", want(), got_cfg)
        `CHK("outputs in reset", 6'h00, {led, chain_addr_out, nvm_wr})
        @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
        for (k = 0; k < 2; k++) begin
            @(posedge mclk);
            chain_in_float <= k[0];
            col = k ? dmxaa_pkg::COL_RED : dmxaa_pkg::COL_PURPLE;
            s = $urandom_range(15, 1);
            send(dmxaa_pkg::OP_STEP, s);
            issue(dmxaa_pkg::OP_AUTO_EN, 0);
            m_step = s;
            m_mode = dmxaa_pkg::MODE_AUTO;
            `CHK("config", want(), got_cfg)
            `CHK("store pulse", 1'b1, nvm_wr)
            count_col(col, IND + 6);
            `CHK("acknowledge cycles", IND, w)
            issue(dmxaa_pkg::OP_ADAPT_EN, 0);
            m_mode = dmxaa_pkg::MODE_ADAPT;
            `CHK("config", want(), got_cfg)
            count_col(col, IND + 6);
            `CHK("acknowledge cycles", IND, w)
            m_addr = $urandom_range(511, 2);
            issue(dmxaa_pkg::OP_ADDR, m_addr);
            m_mode = dmxaa_pkg::MODE_OFF;
            `CHK("config", want(), got_cfg)
        end
        // pass: k 0 is the first chip, 1 addressing, 2 adaptive
        for (k = 0; k < 3; k++) begin
            s = $urandom_range(15, 1);
            t = $urandom_range(4, 1);
            @(posedge mclk);
            learn <= 13'($urandom);
            up_turn <= 4'(t);
            send(dmxaa_pkg::OP_STEP, s);
            send(k == 2 ? dmxaa_pkg::OP_ADAPT_EN : dmxaa_pkg::OP_AUTO_EN, 0);
            repeat (IND + 6) @(posedge mclk);
            m_step = s;
            m_mode = k == 2 ? dmxaa_pkg::MODE_ADAPT : dmxaa_pkg::MODE_AUTO;
            power_up(k == 0);
            @(negedge mclk);
            `CHK("config after power-up", want(), got_cfg)
            nfr = k == 0 ? 1 : t + 1;
            for (j = 0; j < nfr; j++) begin
                frame();
                if (j < nfr - 1) `CHK("chain out", 1'b0, chain_addr_out)
            end
            m_addr = k > 0 ? 1 + t * s : 1;
            m_mode = k > 0 ? dmxaa_pkg::MODE_OFF : m_mode;
            col = k > 0 ? dmxaa_pkg::COL_GREEN : dmxaa_pkg::COL_RED;
            `CHK("config after pass", want(), got_cfg)
            `CHK("chain out", 1'b1, chain_addr_out)
            if (k == 2)
                `CHK("learned", learn, {nvm_data.gain, nvm_data.param})
            count_col(col, IND + 6);
            `CHK("pass colour cycles", IND, w)
            if (k > 0) begin
                power_up(1'b0);
                for (j = 0; j <= t; j++) begin
                    frame();
                end
                @(negedge mclk);
                `CHK("config next power-up", want(), got_cfg)
            end
        end
        send(dmxaa_pkg::OP_SELFCHK, 1);
        power_up(1'b1);
        repeat (2) @(negedge mclk);
        `CHK("open line colour", dmxaa_pkg::COL_RED, led)
        repeat (30) @(negedge mclk);
        `CHK("open line colour", dmxaa_pkg::COL_RED, led)
        send(dmxaa_pkg::OP_SELFCHK, 1);
        repeat (3) @(negedge mclk);
        `CHK("colour after command", dmxaa_pkg::COL_DARK, led)
        power_up(1'b0);
        repeat (3) @(negedge mclk);
        `CHK("connected colour", dmxaa_pkg::COL_DARK, led)
        issue(dmxaa_pkg::OP_AUTO_EN, 0);
        repeat (IND + 6) @(posedge mclk);
        power_up(1'b1);
        repeat (3) @(negedge mclk);
        `CHK("check with auto on", dmxaa_pkg::COL_DARK, led)
        issue(dmxaa_pkg::OP_AUTO_OFF, 0);
        m_mode = dmxaa_pkg::MODE_OFF;
        `CHK("config", want(), got_cfg)
        // width stretch at levels 0 to 7, then switched off
        for (k = 0; k < 9; k++) begin
            send(dmxaa_pkg::OP_COMP, k < 8 ? 8 + k : 0);
            repeat (IND + 6) @(posedge mclk);
            s = $urandom_range(8, 1);
            w = 0;
            for (j = 0; j < 64; j++) begin
                pwm_raw <= j < s ? 4'hF : 4'h0;
                @(negedge mclk);
                if (led === 4'hF) w++;
                @(posedge mclk);
            end
            t = k < 8 ? (k > 6 ? 6 : k) : 0;
            `CHK("stretched width", s + 6 * t, w)
        end
        wrap_up();
    end
endmodule : tb

// [core/dmxaa_ctrl.sv]
`timescale 1ns/100ps

// Operation
// - step set first, then auto addressing enabled; red first, purple rest
// - with auto addressing on, every power-up runs an addressing pass
// - floating chain input takes address 1; others follow by step count
// - address from the pass is stored without any command
// - after addressing, first chip red, others green for two seconds
// - successful pass leaves auto addressing mode by itself
// - adaptive mode enabled by command; red first, purple rest
// - adaptive success lights green two seconds; mode is left one cycle before the green starts
// - only one automatic function selected at a time
// - replacement chip recovers address; adaptive also gain and parameters
// - first chip performs no auto addressing or adaptive recovery
// - explicit address write turns off every automatic function
// - self-check enabled by a parameter write
// - self-check at power-up: red if open or first, dark if connected
// - self-check is inactive while an automatic function is on
// - width compensation enabled by a parameter write
// - compensation level 0..6, 260 ns per level rounded up to 6 cycles, so 300 ns longer on-time per level
module dmxaa_ctrl #(
    parameter int IND_CYCLES = dmxaa_pkg::IND_CYC
) (
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          resetn,
    // decoded controller commands and frame timing
    input  wire dmxaa_pkg::dmxaa_cmd_type      cmd,
    input  wire logic                          frame_start,
    input  wire dmxaa_pkg::dmxaa_learn_type    learn,
    // address chain
    input  wire logic                          chain_addr_in,
    input  wire logic                          chain_in_float,
    output logic                               chain_addr_out,
    // retained storage
    input  wire dmxaa_pkg::dmxaa_cfg_type      nvm_rd,
    output logic                               nvm_wr,
    output dmxaa_pkg::dmxaa_cfg_type           nvm_data,
    // led channels
    input  wire logic [dmxaa_pkg::CH_N-1:0]    pwm_raw,
    output logic [dmxaa_pkg::CH_N-1:0]         led_channel_outputs
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        dmxaa_pkg::dmxaa_phase_type                phase;
        dmxaa_pkg::dmxaa_cfg_type                  cfg;
        logic [dmxaa_pkg::ADDR_W-1:0]              frame_idx;
        logic [dmxaa_pkg::CNT_W-1:0]               ind_cnt;
        logic [dmxaa_pkg::CH_N-1:0]                ind_col;
        logic                                      hold_red;
        logic                                      chain_out;
        logic                                      nvm_wr;
        logic [dmxaa_pkg::CH_N-1:0]                led;
        logic [dmxaa_pkg::CH_N-1:0][dmxaa_pkg::EXT_W-1:0] ext_cnt;
    } dmxaa_state_type;

    dmxaa_state_type st_r;
    dmxaa_state_type st_nxt;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [dmxaa_pkg::CH_N-1:0] ack_colour(
        input logic first);
        return first ? dmxaa_pkg::COL_RED : dmxaa_pkg::COL_PURPLE;
    endfunction : ack_colour

    function automatic logic [dmxaa_pkg::ADDR_W-1:0] chain_addr(
        input logic [dmxaa_pkg::ADDR_W-1:0] idx,
        input logic [dmxaa_pkg::STEP_W-1:0] step);
        logic [dmxaa_pkg::ADDR_W+dmxaa_pkg::STEP_W-1:0] prod;
        prod = idx * step;
        return dmxaa_pkg::FIRST_ADDR + prod[dmxaa_pkg::ADDR_W-1:0];
    endfunction : chain_addr

    function automatic logic [dmxaa_pkg::EXT_W-1:0] comp_cycles(
        input dmxaa_pkg::dmxaa_cfg_type c);
        logic [dmxaa_pkg::EXT_W-1:0] per;
        per = dmxaa_pkg::EXT_W'(dmxaa_pkg::COMP_STEP_CYC);
        return c.comp_en ? dmxaa_pkg::EXT_W'(c.comp_lvl) * per
                         : '0;
    endfunction : comp_cycles

    function automatic logic [dmxaa_pkg::CNT_W-1:0] ind_load();
        return dmxaa_pkg::CNT_W'(IND_CYCLES);
    endfunction : ind_load

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic take;
    logic first;

    always_comb begin
        st_nxt        = st_r;
        st_nxt.nvm_wr = 1'b0;
        first         = chain_in_float;
        take          = frame_start && !st_r.chain_out
                        && (first || chain_addr_in);

        if (st_r.ind_cnt != '0) begin
            st_nxt.ind_cnt = st_r.ind_cnt - 1'b1;
        end

        unique case (st_r.phase)
            // power-up: pick up retained settings
            dmxaa_pkg::PH_LOAD: begin
                st_nxt.cfg = nvm_rd;
                if (nvm_rd.mode != dmxaa_pkg::MODE_OFF) begin
                    st_nxt.phase = dmxaa_pkg::PH_PASS;
                end else begin
                    st_nxt.phase = dmxaa_pkg::PH_RUN;
                    // open line and first chip look alike: both red
                    st_nxt.hold_red = nvm_rd.self_en && first;
                end
            end
            dmxaa_pkg::PH_PASS: begin
                // address index is the count of frames before our turn
                if (take) begin
                    st_nxt.chain_out = 1'b1;
                    st_nxt.phase     = dmxaa_pkg::PH_RUN;
                    st_nxt.ind_cnt   = ind_load();
                    if (first) begin
                        st_nxt.cfg.addr = dmxaa_pkg::FIRST_ADDR;
                        st_nxt.ind_col  = dmxaa_pkg::COL_RED;
                    end else begin
                        st_nxt.cfg.addr = chain_addr(st_r.frame_idx,
                                                     st_r.cfg.step);
                        if (st_r.cfg.mode == dmxaa_pkg::MODE_ADAPT) begin
                            st_nxt.cfg.gain  = learn.gain;
                            st_nxt.cfg.param = learn.param;
                        end
                        st_nxt.cfg.mode = dmxaa_pkg::MODE_OFF;
                        st_nxt.ind_col  = dmxaa_pkg::COL_GREEN;
                        st_nxt.nvm_wr   = 1'b1;
                    end
                end else if (frame_start) begin
                    st_nxt.frame_idx = st_r.frame_idx + 1'b1;
                end
            end
            dmxaa_pkg::PH_RUN: begin
                // keep the chain moving for repaired chips downstream
                if (take) begin
                    st_nxt.chain_out = 1'b1;
                end
            end
        endcase

        // commands, not during the load cycle
        if (cmd.valid && st_r.phase != dmxaa_pkg::PH_LOAD) begin
            st_nxt.nvm_wr   = 1'b1;
            st_nxt.hold_red = 1'b0;
            unique case (cmd.op)
                dmxaa_pkg::OP_STEP: begin
                    st_nxt.cfg.step = cmd.data[dmxaa_pkg::STEP_W-1:0];
                end
                dmxaa_pkg::OP_AUTO_EN: begin
                    st_nxt.cfg.mode = dmxaa_pkg::MODE_AUTO;
                    st_nxt.ind_col  = ack_colour(first);
                    st_nxt.ind_cnt  = ind_load();
                end
                dmxaa_pkg::OP_ADAPT_EN: begin
                    st_nxt.cfg.mode = dmxaa_pkg::MODE_ADAPT;
                    st_nxt.ind_col  = ack_colour(first);
                    st_nxt.ind_cnt  = ind_load();
                end
                dmxaa_pkg::OP_AUTO_OFF: begin
                    st_nxt.cfg.mode = dmxaa_pkg::MODE_OFF;
                end
                dmxaa_pkg::OP_ADDR: begin
                    st_nxt.cfg.addr = cmd.data[dmxaa_pkg::ADDR_W-1:0];
                    st_nxt.cfg.mode = dmxaa_pkg::MODE_OFF;
                    if (st_r.phase == dmxaa_pkg::PH_PASS) begin
                        st_nxt.phase = dmxaa_pkg::PH_RUN;
                    end
                end
                dmxaa_pkg::OP_SELFCHK: begin
                    st_nxt.cfg.self_en =
                        cmd.data[dmxaa_pkg::SELF_EN_BIT];
                end
                dmxaa_pkg::OP_COMP: begin
                    st_nxt.cfg.comp_en =
                        cmd.data[dmxaa_pkg::COMP_EN_BIT];
                    // levels above the top one saturate
                    if (cmd.data[dmxaa_pkg::LVL_W-1:0] > dmxaa_pkg::COMP_MAX)
                    begin
                        st_nxt.cfg.comp_lvl = dmxaa_pkg::COMP_MAX;
                    end else begin
                        st_nxt.cfg.comp_lvl = cmd.data[dmxaa_pkg::LVL_W-1:0];
                    end
                end
                default: begin
                    st_nxt.nvm_wr = 1'b0;
                end
            endcase
        end

        // on-time stretch: each fall is held for the compensation count
        for (int i = 0; i < dmxaa_pkg::CH_N; i++) begin
            if (pwm_raw[i]) begin
                st_nxt.ext_cnt[i] = comp_cycles(st_r.cfg);
            end else if (st_r.ext_cnt[i] != '0) begin
                st_nxt.ext_cnt[i] = st_r.ext_cnt[i] - 1'b1;
            end
            st_nxt.led[i] = pwm_raw[i] || (st_r.ext_cnt[i] != '0);
        end

        // indications override the grey-scale drive
        if (st_r.ind_cnt != '0) begin
            st_nxt.led = st_r.ind_col;
        end else if (st_r.hold_red) begin
            st_nxt.led = dmxaa_pkg::COL_RED;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_r               <= '0;
            st_r.phase         <= dmxaa_pkg::PH_LOAD;
            st_r.cfg.step      <= dmxaa_pkg::STEP_RST;
            st_r.cfg.addr      <= dmxaa_pkg::FIRST_ADDR;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign chain_addr_out      = st_r.chain_out;
    assign nvm_wr              = st_r.nvm_wr;
    assign nvm_data            = st_r.cfg;
    assign led_channel_outputs = st_r.led;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    sequence s_cmd(dmxaa_pkg::dmxaa_op_type op);
        cmd.valid && cmd.op == op && st_r.phase != dmxaa_pkg::PH_LOAD;
    endsequence

    sequence s_take_other;
        st_r.phase == dmxaa_pkg::PH_PASS && take && !first;
    endsequence

    sequence s_quiet;
        !cmd.valid && st_r.ind_cnt == '0;
    endsequence

    auto_ack_a: assert property (
        s_cmd(dmxaa_pkg::OP_AUTO_EN) ##1 !cmd.valid
        |=> led_channel_outputs == ack_colour($past(first, 2)))
        else $error("auto enable indication colour wrong");

    adapt_ack_a: assert property (
        s_cmd(dmxaa_pkg::OP_ADAPT_EN) ##1 !cmd.valid
        |=> led_channel_outputs == ack_colour($past(first, 2))
            && nvm_data.mode == dmxaa_pkg::MODE_ADAPT)
        else $error("adaptive enable not taken");

    pass_start_a: assert property (
        st_r.phase == dmxaa_pkg::PH_LOAD
        && nvm_rd.mode != dmxaa_pkg::MODE_OFF
        |=> st_r.phase == dmxaa_pkg::PH_PASS)
        else $error("power-up pass not started");

    first_addr_a: assert property (
        st_r.phase == dmxaa_pkg::PH_PASS && take && first && !cmd.valid
        |=> nvm_data.addr == dmxaa_pkg::FIRST_ADDR && chain_addr_out
            && nvm_data.mode == $past(nvm_data.mode))
        else $error("first chip address or mode wrong");

    step_addr_a: assert property (
        s_take_other ##0 !cmd.valid
        |=> nvm_data.addr == chain_addr($past(st_r.frame_idx),
                                        $past(nvm_data.step)))
        else $error("chained address not advanced by step");

    pass_done_a: assert property (
        s_take_other ##0 !cmd.valid
        |=> nvm_wr && nvm_data.mode == dmxaa_pkg::MODE_OFF)
        else $error("pass result not stored or mode kept");

    green_show_a: assert property (
        s_take_other ##0 !cmd.valid ##1 !cmd.valid
        |=> led_channel_outputs == dmxaa_pkg::COL_GREEN)
        else $error("success indication not green");

    adapt_learn_a: assert property (
        s_take_other ##0 !cmd.valid
        ##0 nvm_data.mode == dmxaa_pkg::MODE_ADAPT
        |=> nvm_data.gain == $past(learn.gain)
            && nvm_data.param == $past(learn.param))
        else $error("adaptive gain or parameters not recovered");

    addr_write_a: assert property (
        s_cmd(dmxaa_pkg::OP_ADDR)
        |=> nvm_data.mode == dmxaa_pkg::MODE_OFF
            && st_r.phase != dmxaa_pkg::PH_PASS)
        else $error("address write left an automatic function on");

    self_store_a: assert property (
        s_cmd(dmxaa_pkg::OP_SELFCHK)
        |=> nvm_wr
            && nvm_data.self_en == $past(cmd.data[dmxaa_pkg::SELF_EN_BIT]))
        else $error("self-check enable not stored");

    comp_store_a: assert property (
        s_cmd(dmxaa_pkg::OP_COMP)
        |=> nvm_wr
            && nvm_data.comp_en == $past(cmd.data[dmxaa_pkg::COMP_EN_BIT]))
        else $error("compensation enable not stored");

    self_red_a: assert property (
        st_r.phase == dmxaa_pkg::PH_LOAD && nvm_rd.self_en && first
        && nvm_rd.mode == dmxaa_pkg::MODE_OFF ##1 s_quiet
        |=> led_channel_outputs == dmxaa_pkg::COL_RED)
        else $error("self-check red not shown");

    self_off_a: assert property (
        st_r.phase == dmxaa_pkg::PH_LOAD
        && nvm_rd.mode != dmxaa_pkg::MODE_OFF
        |=> !st_r.hold_red)
        else $error("self-check active with automatic function");

    chain_order_a: assert property (
        $rose(chain_addr_out)
        |-> $past(frame_start) && $past(first || chain_addr_in))
        else $error("chain output raised before address turn");

    comp_max_a: assert property (
        nvm_data.comp_lvl <= dmxaa_pkg::COMP_MAX)
        else $error("compensation level above six");

    comp_one_a: assert property (
        $fell(pwm_raw[0]) && nvm_data.comp_en && nvm_data.comp_lvl == 3'h1
        && st_r.ind_cnt == '0 && !st_r.hold_red && !pwm_raw[0]
        |=> led_channel_outputs[0] [*6] ##1 !led_channel_outputs[0])
        else $error("level one stretch not six cycles");

endmodule : dmxaa_ctrl

// [core/dmxaa_pkg.sv]
package dmxaa_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W  = 9;
    localparam int STEP_W  = 9;
    localparam int GAIN_W  = 5;
    localparam int PARAM_W = 8;
    localparam int LVL_W   = 3;
    localparam int CH_N    = 4;
    localparam int CNT_W   = 32;
    localparam int EXT_W   = 6;

    // ------------------------------------------------------------
    // values and timing
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] FIRST_ADDR   = 9'h001;
    localparam logic [STEP_W-1:0] STEP_RST     = 9'h001;
    localparam logic [LVL_W-1:0]  COMP_MAX     = 3'h6;
    localparam int                CLK_NS       = 50;
    localparam int                COMP_STEP_NS = 260;
    localparam int COMP_STEP_CYC = (COMP_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int                IND_TIME_MS  = 2000;
    localparam int IND_CYC = IND_TIME_MS * (1000000 / CLK_NS);

    // channel bits: 0 red, 1 green, 2 blue, 3 white
    localparam logic [CH_N-1:0] COL_DARK   = 4'h0;
    localparam logic [CH_N-1:0] COL_RED    = 4'h1;
    localparam logic [CH_N-1:0] COL_GREEN  = 4'h2;
    localparam logic [CH_N-1:0] COL_PURPLE = 4'h5;

    // command data field positions
    localparam int SELF_EN_BIT = 0;
    localparam int COMP_EN_BIT = 3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MODE_OFF, MODE_AUTO, MODE_ADAPT}
        dmxaa_mode_type;

    typedef enum logic [2:0] {OP_STEP, OP_AUTO_EN, OP_ADAPT_EN,
        OP_AUTO_OFF, OP_ADDR, OP_SELFCHK, OP_COMP} dmxaa_op_type;

    typedef enum logic [1:0] {PH_LOAD, PH_PASS, PH_RUN} dmxaa_phase_type;

    typedef struct packed {
        logic         valid;
        dmxaa_op_type op;
        logic [15:0]  data;
    } dmxaa_cmd_type;

    typedef struct packed {
        logic [GAIN_W-1:0]  gain;
        logic [PARAM_W-1:0] param;
    } dmxaa_learn_type;

    typedef struct packed {
        logic [ADDR_W-1:0]  addr;
        logic [STEP_W-1:0]  step;
        dmxaa_mode_type     mode;
        logic               self_en;
        logic               comp_en;
        logic [LVL_W-1:0]   comp_lvl;
        logic [GAIN_W-1:0]  gain;
        logic [PARAM_W-1:0] param;
    } dmxaa_cfg_type;

endpackage : dmxaa_pkg
